// ---- level_sweep_pkg.sv ----
// Constants and types shared by the level sweep sequencer.
// Assumes levels are signed fixed point in 1/100 dB units.
package level_sweep_pkg;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int LEVEL_W = 16;
    localparam int DWELL_W = 24;
    localparam logic [15:0] LEVEL_RST = 16'h0000;
    localparam logic [23:0] DWELL_RST = 24'h000000;
    localparam logic [1:0] SYNC_RST = 2'h0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_AUTO = 3'h0,
        MODE_SINGLE = 3'h1,
        MODE_STEP = 3'h2,
        MODE_EXT_SINGLE = 3'h3,
        MODE_EXT_STEP = 3'h4,
        MODE_EXT_START_STOP = 3'h5
    } sweep_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_RUN = 2'h1,
        ST_FROZEN = 2'h2
    } sweep_state_t;

endpackage

// ---- trigger_edge_detect.sv ----
// Synchroniser and single-edge detector for the instrument trigger input.
// Assumes the trigger is asynchronous to core_clk.
`timescale 1ns/1ps
module trigger_edge_detect (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic instrument_trigger_input,
    input wire logic slope_negative,
    output logic trigger_event
);
    typedef struct packed {
        logic [1:0] sync;
        logic last;
        logic event_out;
    } edge_state_t;

    edge_state_t state_ff;
    edge_state_t nxt_state;

    // ------------------------------------------------------------------
    // Edge logic
    // ------------------------------------------------------------------
    // Only the second sync stage feeds the comparison; the first stage is
    // left alone to settle.
    always_comb begin
        nxt_state = state_ff;
        nxt_state.sync = {state_ff.sync[0], instrument_trigger_input};
        nxt_state.last = state_ff.sync[1];
        nxt_state.event_out = slope_negative ?
            (state_ff.last & ~state_ff.sync[1]) :
            (~state_ff.last & state_ff.sync[1]);
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign trigger_event = state_ff.event_out;
endmodule

// ---- rf_level_sweep_sequencer.sv ----
// Stepped RF level sweep sequencer: modes, shapes, dwell and triggers.
// Assumes all control inputs except instrument_trigger_input are synchronous to core_clk and that
// level_start <= level_stop.
`timescale 1ns/1ps
module rf_level_sweep_sequencer (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic sweep_enable,
    input wire level_sweep_pkg::sweep_mode_t sweep_mode,
    input wire logic shape_triangle,
    input wire logic slope_negative,
    input wire logic signed [15:0] level_start,
    input wire logic signed [15:0] level_stop,
    input wire logic [15:0] level_step,
    input wire logic [23:0] dwell_cycles,
    input wire logic [23:0] settle_cycles,
    input wire logic execute_sweep,
    input wire logic reset_sweep,
    input wire logic level_write,
    input wire logic signed [15:0] level_write_value,
    input wire logic instrument_trigger_input,
    output logic signed [15:0] level_out,
    output logic level_update,
    output logic level_settled,
    output logic sweep_running,
    output logic other_sweeps_off
);
    typedef struct packed {
        level_sweep_pkg::sweep_state_t state;
        level_sweep_pkg::sweep_mode_t mode;
        logic enabled;
        logic descending;
        logic [15:0] level;
        logic [23:0] dwell;
        logic update;
        logic settled;
        logic running;
        logic others_off;
    } seq_state_t;

    seq_state_t state_ff;
    seq_state_t nxt_state;
    logic trig;
    logic signed [16:0] up_sum;
    logic signed [16:0] down_sum;
    logic step_now;
    logic at_stop;
    logic at_start;

    // ------------------------------------------------------------------
    // Trigger input
    // ------------------------------------------------------------------
    trigger_edge_detect u_trig (
        .core_clk(core_clk),
        .nrst(nrst),
        .instrument_trigger_input(instrument_trigger_input),
        .slope_negative(slope_negative),
        .trigger_event(trig)
    );

    // ------------------------------------------------------------------
    // Step arithmetic
    // ------------------------------------------------------------------
    // One extra bit keeps the overflow visible so the clamp sees it.
    assign up_sum = $signed({state_ff.level[15], state_ff.level})
        + $signed({1'b0, level_step});
    assign down_sum = $signed({state_ff.level[15], state_ff.level})
        - $signed({1'b0, level_step});
    assign at_stop = $signed(state_ff.level) >= level_stop;
    assign at_start = $signed(state_ff.level) <= level_start;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // The level write value is never stored; only its strobe counts.
    always_comb begin
        nxt_state = state_ff;
        nxt_state.update = 1'b0;
        step_now = 1'b0;
        nxt_state.enabled = sweep_enable;
        nxt_state.mode = sweep_mode;
        nxt_state.others_off = sweep_enable;
        if (state_ff.dwell != '0) begin
            nxt_state.dwell = state_ff.dwell - 24'h000001;
        end
        if (!sweep_enable) begin
            nxt_state.state = level_sweep_pkg::ST_IDLE;
        end else if (!state_ff.enabled || sweep_mode != state_ff.mode) begin
            // Mode entry: auto resumes, every other mode halts.
            if (sweep_mode == level_sweep_pkg::MODE_AUTO) begin
                nxt_state.state = level_sweep_pkg::ST_RUN;
                nxt_state.dwell = dwell_cycles;
            end else begin
                nxt_state.state = level_sweep_pkg::ST_IDLE;
            end
            if (sweep_mode == level_sweep_pkg::MODE_EXT_STEP ||
                sweep_mode == level_sweep_pkg::MODE_EXT_SINGLE) begin
                nxt_state.level = level_start;
                nxt_state.descending = 1'b0;
                nxt_state.update = 1'b1;
                nxt_state.dwell = dwell_cycles;
            end
        end else if (reset_sweep) begin
            nxt_state.level = level_start;
            nxt_state.descending = 1'b0;
            nxt_state.update = 1'b1;
            nxt_state.dwell = dwell_cycles;
        end else begin
            case (sweep_mode)
                level_sweep_pkg::MODE_AUTO: begin
                    nxt_state.state = level_sweep_pkg::ST_RUN;
                    step_now = state_ff.dwell == '0;
                end
                level_sweep_pkg::MODE_SINGLE,
                level_sweep_pkg::MODE_EXT_SINGLE: begin
                    if ((execute_sweep &&
                         sweep_mode == level_sweep_pkg::MODE_SINGLE) ||
                        (trig && sweep_mode ==
                         level_sweep_pkg::MODE_EXT_SINGLE)) begin
                        nxt_state.state = level_sweep_pkg::ST_RUN;
                        nxt_state.level = level_start;
                        nxt_state.descending = 1'b0;
                        nxt_state.update = 1'b1;
                        nxt_state.dwell = dwell_cycles;
                    end else if (state_ff.state == level_sweep_pkg::ST_RUN)
                    begin
                        step_now = state_ff.dwell == '0;
                    end
                end
                level_sweep_pkg::MODE_STEP: begin
                    step_now = level_write;
                end
                level_sweep_pkg::MODE_EXT_STEP: begin
                    step_now = trig;
                end
                level_sweep_pkg::MODE_EXT_START_STOP: begin
                    if (trig) begin
                        case (state_ff.state)
                            level_sweep_pkg::ST_RUN: begin
                                nxt_state.state = level_sweep_pkg::ST_FROZEN;
                            end
                            default: begin
                                // Idle or frozen: both start over at start.
                                nxt_state.state = level_sweep_pkg::ST_RUN;
                                nxt_state.level = level_start;
                                nxt_state.descending = 1'b0;
                                nxt_state.update = 1'b1;
                                nxt_state.dwell = dwell_cycles;
                            end
                        endcase
                    end else if (state_ff.state == level_sweep_pkg::ST_RUN)
                    begin
                        step_now = state_ff.dwell == '0;
                    end
                end
                default: begin
                    nxt_state.state = level_sweep_pkg::ST_IDLE;
                end
            endcase
        end
        if (step_now) begin
            nxt_state.update = 1'b1;
            nxt_state.dwell = dwell_cycles;
            if (state_ff.descending) begin
                if (at_start || down_sum <= $signed({level_start[15],
                    level_start})) begin
                    // Downslope done: cycle ends at start level.
                    nxt_state.level = level_start;
                    nxt_state.descending = 1'b0;
                    if (sweep_mode == level_sweep_pkg::MODE_SINGLE ||
                        sweep_mode == level_sweep_pkg::MODE_EXT_SINGLE) begin
                        nxt_state.state = level_sweep_pkg::ST_IDLE;
                    end
                end else begin
                    nxt_state.level = down_sum[15:0];
                end
            end else if (at_stop) begin
                if (shape_triangle) begin
                    nxt_state.descending = 1'b1;
                    nxt_state.level = down_sum[15:0];
                end else if (sweep_mode == level_sweep_pkg::MODE_SINGLE ||
                    sweep_mode == level_sweep_pkg::MODE_EXT_SINGLE ||
                    sweep_mode == level_sweep_pkg::MODE_STEP) begin
                    nxt_state.state = level_sweep_pkg::ST_IDLE;
                    nxt_state.update = 1'b0;
                end else begin
                    nxt_state.level = level_start;
                end
            end else if (up_sum > $signed({level_stop[15], level_stop}))
            begin
                nxt_state.level = level_stop;
            end else begin
                nxt_state.level = up_sum[15:0];
            end
        end
        // Settling eats into dwell rather than extending it, so the flag
        // stays low for the first settle_cycles of every new step.
        nxt_state.settled = (dwell_cycles - nxt_state.dwell) >=
            settle_cycles;
        nxt_state.running = sweep_enable &&
            nxt_state.state == level_sweep_pkg::ST_RUN;
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign level_out = state_ff.level;
    assign level_update = state_ff.update;
    assign level_settled = state_ff.settled;
    assign sweep_running = state_ff.running;
    assign other_sweeps_off = state_ff.others_off;
endmodule

// ---- sweep_props.sv ----
// Checker for the level sweep sequencer, watching its top ports only.
// Assumes start <= stop and steady step, dwell and settle settings.
`timescale 1ns/1ps
module sweep_props (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic sweep_enable,
    input wire level_sweep_pkg::sweep_mode_t sweep_mode,
    input wire logic signed [15:0] level_start,
    input wire logic signed [15:0] level_stop,
    input wire logic [15:0] level_step,
    input wire logic [23:0] dwell_cycles,
    input wire logic [23:0] settle_cycles,
    input wire logic execute_sweep,
    input wire logic reset_sweep,
    input wire logic level_write,
    input wire logic signed [15:0] level_out,
    input wire logic level_update,
    input wire logic level_settled,
    input wire logic sweep_running,
    input wire logic other_sweeps_off
);
    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    logic signed [16:0] sum;
    logic signed [15:0] clamp;
    logic [24:0] gap_ff;
    logic gap_ok_ff;
    logic armed;
    // Next level with the stop clamp; one extra bit keeps overflow out.
    assign sum = level_out + $signed({1'b0, level_step});
    assign clamp = (sum > level_stop) ? level_stop : sum[15:0];
    assign armed = sweep_enable && other_sweeps_off;
    // The gap is trusted only once a steady auto run has shown an update.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            gap_ff <= 25'h0000000;
            gap_ok_ff <= 1'b0;
        end else begin
            gap_ff <= level_update ? 25'h0000001 : gap_ff + 25'h0000001;
            gap_ok_ff <= sweep_running && (level_update || gap_ok_ff) &&
                (sweep_mode == level_sweep_pkg::MODE_AUTO);
        end
    end
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    a_enable_off: assert property (
        sweep_enable |=> other_sweeps_off)
        else $error("other sweeps left on");
    a_exec_start: assert property (
        armed && execute_sweep && !reset_sweep && $stable(sweep_mode) &&
        sweep_mode == level_sweep_pkg::MODE_SINGLE
        |=> level_update && level_out == level_start)
        else $error("single sweep did not start at start level");
    a_exec_refused: assert property (
        execute_sweep && !level_write && !reset_sweep &&
        sweep_mode == level_sweep_pkg::MODE_STEP |=> !level_update)
        else $error("execute acted outside single mode");
    a_reset_start: assert property (
        armed && reset_sweep && $stable(sweep_mode)
        |=> level_out == level_start)
        else $error("reset sweep did not load start level");
    a_step_write: assert property (
        armed && level_write && !reset_sweep && $stable(sweep_mode) &&
        sweep_mode == level_sweep_pkg::MODE_STEP && level_out < level_stop
        |=> level_update && level_out == $past(clamp))
        else $error("level write gave wrong step");
    a_level_range: assert property (
        level_update |-> level_out >= level_start && level_out <= level_stop)
        else $error("level left the start to stop range");
    a_dwell_gap: assert property (
        level_update && gap_ok_ff && $stable(sweep_mode)
        |-> gap_ff == dwell_cycles + 25'h0000001)
        else $error("step period differs from dwell");
    a_settle_low: assert property (
        level_update && settle_cycles != 24'h000000 |-> !level_settled)
        else $error("settled flag high at a new step");
endmodule

// ---- trigger_source_model.sv ----
// Behavioural source for the instrument trigger input.
// Assumes the bench calls fire and lets time pass between calls.
`timescale 1ns/1ps
module trigger_source_model (
    output logic instrument_trigger_input
);
    // Idle sits opposite the active edge, so one pulse holds one active
    // edge; the odd delays keep its phase apart from the core clock.
    initial instrument_trigger_input = 1'b0;
    task automatic fire(input logic neg, input int width_ns);
        instrument_trigger_input = neg;
        #7;
        instrument_trigger_input = !neg;
        #(width_ns);
        instrument_trigger_input = neg;
        #3;
    endtask
endmodule

// ---- testbench.sv ----
// Self-checking bench: a table of sweep cases, then hand-written cases.
// Assumes the checker and the trigger source model are compiled first.
`timescale 1ns/1ps
module testbench;
    // ------------------------------------------------------------------
    // Signals, table and tasks
    // ------------------------------------------------------------------
    typedef struct {
        level_sweep_pkg::sweep_mode_t mode;
        logic tri_s;
        logic [15:0] step;
        int kind, nev, off, n;
    } row_t;
    localparam logic signed [15:0] START_LVL = 16'h0064;
    localparam logic signed [15:0] STOP_LVL = 16'h0190;
    logic core_clk = 1'b0, nrst = 1'b0, sweep_enable = 1'b0;
    logic shape_triangle = 1'b0, slope_negative = 1'b0;
    level_sweep_pkg::sweep_mode_t sweep_mode = level_sweep_pkg::MODE_STEP;
    logic [15:0] level_step = 16'h0078;
    logic execute_sweep = 1'b0, reset_sweep = 1'b0, level_write = 1'b0;
    logic signed [15:0] level_out, hold;
    logic level_update, level_settled, sweep_running, other_sweeps_off;
    wire logic instrument_trigger_input;
    int errors = 0, cmp_count = 0;
    logic signed [15:0] cap [$];
    row_t rows [6];
    always #5 core_clk = ~core_clk;
    // Log each announced level at the falling edge, where it is settled.
    always @(negedge core_clk) begin
        if (level_update === 1'b1) cap.push_back(level_out);
    end
    rf_level_sweep_sequencer dut (.level_start(START_LVL),
        .level_stop(STOP_LVL), .dwell_cycles(24'h000003),
        .settle_cycles(24'h000001), .level_write_value(16'h0096), .*);
    trigger_source_model src (
        .instrument_trigger_input(instrument_trigger_input)
    );
    task automatic chk_lvl(input logic signed [15:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask
    // Halt in step mode and reload start, so every case begins alike.
    // The log is cleared after mode entry, so an entry reload is not
    // counted as a step of the case.
    task automatic prep(input level_sweep_pkg::sweep_mode_t m);
        sweep_mode = level_sweep_pkg::MODE_STEP;
        cyc(2);
        pulse(reset_sweep);
        cyc(2);
        sweep_mode = m;
        cyc(2);
        cap.delete();
    endtask
    task automatic summarize;
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Level k steps into a run; triangle turns at stop, sawtooth wraps.
    function automatic logic signed [15:0] lvl_at(input logic t,
        input logic [15:0] st, input int k);
        logic signed [16:0] lv;
        logic up;
        lv = START_LVL;
        up = 1'b1;
        repeat (k) begin
            if (up && lv == STOP_LVL) begin
                up = !t;
                lv = t ? lv - $signed({1'b0, st}) : START_LVL;
            end else if (up) lv = lv + $signed({1'b0, st});
            else lv = lv - $signed({1'b0, st});
            if (lv > STOP_LVL) lv = STOP_LVL;
            if (lv < START_LVL) lv = START_LVL;
            if (!up && lv == START_LVL) up = 1'b1;
        end
        return lv[15:0];
    endfunction
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rows[0] = '{level_sweep_pkg::MODE_SINGLE, 1'b0, 16'h0078, 0, 1, 0, 4};
        rows[1] = '{level_sweep_pkg::MODE_SINGLE, 1'b1, 16'h0064, 0, 1, 0, 7};
        rows[2] = '{level_sweep_pkg::MODE_EXT_SINGLE, 1'b0, 16'h0078,
            2, 1, 0, 4};
        rows[3] = '{level_sweep_pkg::MODE_EXT_STEP, 1'b0, 16'h0078,
            2, 3, 1, 3};
        rows[4] = '{level_sweep_pkg::MODE_STEP, 1'b0, 16'h0078, 1, 3, 1, 3};
        rows[5] = '{level_sweep_pkg::MODE_AUTO, 1'b0, 16'h0078, 0, 0, 1, 4};
        cyc(4);
        chk_lvl(level_out, 16'h0000);
        chk_bit(level_update | sweep_running | other_sweeps_off, 1'b0);
        nrst = 1'b1;
        sweep_enable = 1'b1;
        cyc(2);
        chk_bit(other_sweeps_off, 1'b1);
        foreach (rows[r]) begin
            shape_triangle = rows[r].tri_s;
            level_step = rows[r].step;
            prep(rows[r].mode);
            for (int j = 0; j < rows[r].nev; j++) begin
                if (rows[r].kind == 0) pulse(execute_sweep);
                else if (rows[r].kind == 1) pulse(level_write);
                else src.fire(1'b0, 20);
                cyc(30);
            end
            cyc(40);
            chk_bit(cap.size() >= rows[r].n, 1'b1);
            for (int j = 0; j < rows[r].n && j < cap.size(); j++) begin
                hold = lvl_at(rows[r].tri_s, rows[r].step, rows[r].off + j);
                chk_lvl(cap[j], hold);
            end
        end
        prep(level_sweep_pkg::MODE_STEP);
        pulse(execute_sweep);
        cyc(20);
        chk_bit(cap.size() == 0, 1'b1);
        prep(level_sweep_pkg::MODE_EXT_START_STOP);
        src.fire(1'b0, 20);
        cyc(27);
        chk_lvl(cap[0], START_LVL);
        chk_bit(sweep_running, 1'b1);
        src.fire(1'b0, 20);
        cyc(10);
        hold = level_out;
        cyc(30);
        chk_lvl(level_out, hold);
        chk_bit(sweep_running, 1'b0);
        cap.delete();
        src.fire(1'b0, 20);
        cyc(20);
        chk_lvl(cap[0], START_LVL);
        slope_negative = 1'b1;
        prep(level_sweep_pkg::MODE_EXT_STEP);
        src.fire(1'b1, 300);
        cyc(40);
        chk_bit(cap.size() == 1, 1'b1);
        chk_bit(level_settled, 1'b1);
        sweep_enable = 1'b0;
        cyc(3);
        chk_bit(other_sweeps_off | sweep_running, 1'b0);
        summarize();
    end
    // Cuts a hang short.
    initial begin
        #500000;
        errors++;
        summarize();
    end
endmodule
bind rf_level_sweep_sequencer sweep_props chk (.*);
